// [hw/reset_source_pkg.sv]
package reset_source_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ              = 20_000_000;
  localparam int unsigned LATCH_EXIT_US       = 2000;
  localparam int unsigned RELEASE_DELAY_US    = 20000;
  localparam int unsigned PIN_FILTER_NS       = 10000;
  localparam int unsigned LATCH_EXIT_CYCLES   = LATCH_EXIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RELEASE_DELAY_CYCLES = RELEASE_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PIN_FILTER_CYCLES   = (PIN_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned HOLD_TIME_CYCLES    = 2000;
  localparam int unsigned CNT_W               = 20;

  // ----------------------------------------
  // APB map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONFIG   = 8'h00;
  localparam logic [7:0] ADDR_LOW_BAT_CFG = 8'h04;
  localparam logic [7:0] ADDR_DRIVER   = 8'h08;
  localparam logic [7:0] ADDR_LOW_BAT_DRV = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_MASK     = 8'h14;
  localparam logic [7:0] ADDR_COMMAND  = 8'h18;
  localparam logic [7:0] ADDR_STATE    = 8'h1C;

  // Driver register bit 0 is the global output disable
  localparam int unsigned DRV_DISABLE_BIT = 0;
  localparam logic [31:0] DRIVER_RESET    = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

  // Status flag positions
  localparam int unsigned FLAG_SUPPLY_OV  = 0;
  localparam int unsigned FLAG_BATTERY_OV = 1;
  localparam int unsigned FLAG_LINK_FAIL  = 2;
  localparam int unsigned FLAG_LATCH_EXIT = 3;
  localparam int unsigned FLAG_W          = 4;

  // Command register bit 0 issues a software reset
  localparam int unsigned CMD_SOFT_RESET  = 0;
  // Config bit 0 enables the latch-exit reset option
  localparam int unsigned CFG_LATCH_EXIT  = 0;

  typedef enum logic [1:0] {
    PIN_RELEASED,
    PIN_RELEASE_WAIT,
    PIN_LATCH_EXIT
  } pin_state_type;

endpackage : reset_source_pkg

// [hw/reset_counter.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Saturating up counter, cleared by clear
// ----------------------------------------
module reset_counter #(
  parameter int unsigned WIDTH = 20
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             clear,
  input  wire logic             enable,
  output var  logic [WIDTH-1:0] count
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } state_type;

  state_type state_q;
  state_type state_d;

  // Count while enabled, hold at top
  always_comb begin
    state_d = state_q;
    if (clear) begin
      state_d.cnt = '0;
    end else if (enable && (state_q.cnt != {WIDTH{1'b1}})) begin
      state_d.cnt = state_q.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign count = state_q.cnt;

endmodule : reset_counter
`default_nettype wire

// [hw/reset_source_manager.sv]
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module reset_source_manager #(
  parameter int unsigned LATCH_EXIT_CYCLES    = reset_source_pkg::LATCH_EXIT_CYCLES,
  parameter int unsigned RELEASE_DELAY_CYCLES = reset_source_pkg::RELEASE_DELAY_CYCLES,
  parameter int unsigned HOLD_TIME_CYCLES     = reset_source_pkg::HOLD_TIME_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Monitor events
  input  wire logic        supply_ok,
  input  wire logic        supply_overvoltage,
  input  wire logic        battery_ov_window,
  input  wire logic        battery_ov_long,
  input  wire logic        link_activity_timeout,
  input  wire logic        power_latch_mode,
  input  wire logic        ignition_in,
  // Open-drain reset pin
  input  wire logic        reset_pin_in,
  output var  logic        reset_pin_out,
  output var  logic        reset_pin_oe_n,
  // Domain reset pulses, regulator switch-off and interrupt
  output var  logic        driver_domain_reset,
  output var  logic        low_battery_domain_reset,
  output var  logic        link_watchdog_reset,
  output var  logic        transceiver_reset,
  output var  logic        regulators_off,
  output var  logic        irq
);

  typedef struct packed {
    logic [31:0]                         config_reg;
    logic [31:0]                         low_battery_config;
    logic [31:0]                         driver_ctrl;
    logic [31:0]                         low_battery_ctrl;
    logic [reset_source_pkg::FLAG_W-1:0] flags;
    logic [reset_source_pkg::FLAG_W-1:0] mask;
    reset_source_pkg::pin_state_type     pin_state;
    logic                                ign_prev;
    logic                                was_low;
    logic                                ov_seen;
    logic [31:0]                         prdata;
    logic                                pready;
    logic                                pslverr;
    logic                                pin_drive;
    logic                                drv_rst;
    logic                                low_battery_rst;
    logic                                wd_rst;
    logic                                xcv_rst;
    logic                                reg_off;
    logic                                irq;
  } state_type;

  state_type state_q;
  state_type state_d;

  // ----------------------------------------
  // Timers outside every reset domain
  // ----------------------------------------
  logic [reset_source_pkg::CNT_W-1:0] pin_low_count;
  logic [reset_source_pkg::CNT_W-1:0] timer_count;
  logic                               timer_clear;
  logic                               pin_ext_low;

  // External low only counted while we do not drive
  assign pin_ext_low = !reset_pin_in && !state_q.pin_drive;

  reset_counter #(.WIDTH(reset_source_pkg::CNT_W)) pin_low_counter (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clear   (!pin_ext_low),
    .enable  (pin_ext_low),
    .count   (pin_low_count)
  );

  reset_counter #(.WIDTH(reset_source_pkg::CNT_W)) delay_timer (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clear   (timer_clear),
    .enable  (1'b1),
    .count   (timer_count)
  );

  // Release delay restarts while the supply is bad, latch exit on entry
  assign timer_clear = (state_q.pin_state != state_d.pin_state)
                       || !supply_ok
                       || battery_ov_long;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic access;
    logic rd_status;
    logic soft_rst;
    logic ext_end;
    logic ext_long;
    logic full_rst;
    logic [reset_source_pkg::FLAG_W-1:0] set_flags;
    access    = 1'b0;
    rd_status = 1'b0;
    soft_rst  = 1'b0;
    ext_end   = 1'b0;
    ext_long  = 1'b0;
    full_rst  = 1'b0;
    set_flags = '0;
    state_d   = state_q;

    // APB access phase, one wait state
    state_d.pready  = 1'b0;
    state_d.pslverr = 1'b0;
    access = psel && penable && !state_q.pready;
    if (access) begin
      state_d.pready = 1'b1;
      state_d.prdata = reset_source_pkg::ZERO_WORD;
      case (paddr)
        reset_source_pkg::ADDR_CONFIG: begin
          if (pwrite) state_d.config_reg = pwdata;
          else state_d.prdata = state_q.config_reg;
        end
        reset_source_pkg::ADDR_LOW_BAT_CFG: begin
          if (pwrite) state_d.low_battery_config = pwdata;
          else state_d.prdata = state_q.low_battery_config;
        end
        reset_source_pkg::ADDR_DRIVER: begin
          if (pwrite) state_d.driver_ctrl = pwdata;
          else state_d.prdata = state_q.driver_ctrl;
        end
        reset_source_pkg::ADDR_LOW_BAT_DRV: begin
          if (pwrite) state_d.low_battery_ctrl = pwdata;
          else state_d.prdata = state_q.low_battery_ctrl;
        end
        reset_source_pkg::ADDR_STATUS: begin
          state_d.prdata[reset_source_pkg::FLAG_W-1:0] = state_q.flags;
          rd_status = !pwrite;
        end
        reset_source_pkg::ADDR_MASK: begin
          if (pwrite) state_d.mask = pwdata[reset_source_pkg::FLAG_W-1:0];
          else state_d.prdata[reset_source_pkg::FLAG_W-1:0] = state_q.mask;
        end
        reset_source_pkg::ADDR_COMMAND: begin
          soft_rst = pwrite && pwdata[reset_source_pkg::CMD_SOFT_RESET];
        end
        reset_source_pkg::ADDR_STATE: begin
          state_d.prdata[1:0] = state_q.pin_state;
          state_d.prdata[2]   = state_q.pin_drive;
        end
        default: state_d.pslverr = 1'b1;
      endcase
    end

    // External pin: filtered, then long or short on release
    state_d.was_low = pin_ext_low && (pin_low_count >= reset_source_pkg::PIN_FILTER_CYCLES);
    ext_end  = state_q.was_low && !state_d.was_low;
    ext_long = pin_low_count >= HOLD_TIME_CYCLES[reset_source_pkg::CNT_W-1:0];

    // Reset pin state machine
    state_d.ign_prev = ignition_in;
    case (state_q.pin_state)
      reset_source_pkg::PIN_RELEASED: begin
        if (!supply_ok || battery_ov_long) begin
          state_d.pin_state = reset_source_pkg::PIN_RELEASE_WAIT;
        end else if (power_latch_mode && state_q.config_reg[reset_source_pkg::CFG_LATCH_EXIT]
                     && ignition_in && !state_q.ign_prev) begin
          state_d.pin_state = reset_source_pkg::PIN_LATCH_EXIT;
          set_flags[reset_source_pkg::FLAG_LATCH_EXIT] = 1'b1;
        end
      end
      reset_source_pkg::PIN_RELEASE_WAIT: begin
        if (!supply_ok || battery_ov_long) begin
          state_d.pin_state = reset_source_pkg::PIN_RELEASE_WAIT;
        end else if (timer_count >= RELEASE_DELAY_CYCLES[reset_source_pkg::CNT_W-1:0]) begin
          state_d.pin_state = reset_source_pkg::PIN_RELEASED;
        end
      end
      reset_source_pkg::PIN_LATCH_EXIT: begin
        if (timer_count >= LATCH_EXIT_CYCLES[reset_source_pkg::CNT_W-1:0] - 1) begin
          state_d.pin_state = reset_source_pkg::PIN_RELEASED;
        end
      end
      default: state_d.pin_state = reset_source_pkg::PIN_RELEASED;
    endcase
    if ((!supply_ok || battery_ov_long) && state_q.pin_state != reset_source_pkg::PIN_RELEASE_WAIT) begin
      state_d.pin_state = reset_source_pkg::PIN_RELEASE_WAIT;
    end
    state_d.pin_drive = (state_d.pin_state != reset_source_pkg::PIN_RELEASED);
    // Battery overvoltage flag, once per long episode
    if (battery_ov_long && !state_q.ov_seen) begin
      set_flags[reset_source_pkg::FLAG_BATTERY_OV] = 1'b1;
    end
    state_d.ov_seen = battery_ov_long || battery_ov_window;

    // Which domains clear this cycle
    full_rst = state_q.pin_drive || soft_rst || (ext_end && ext_long);
    state_d.drv_rst = full_rst || ext_end || supply_overvoltage || battery_ov_window
                      || link_activity_timeout;
    state_d.low_battery_rst = full_rst || battery_ov_window;
    state_d.wd_rst  = full_rst || ext_end || supply_overvoltage || battery_ov_window;
    state_d.xcv_rst = full_rst || ext_end;
    state_d.reg_off = battery_ov_long;

    // Configuration domain
    if (full_rst || ext_end) begin
      state_d.config_reg = reset_source_pkg::ZERO_WORD;
    end
    // Low-battery configuration kept apart
    if (full_rst) begin
      state_d.low_battery_config = reset_source_pkg::ZERO_WORD;
    end
    // Driver control domain, global disable set
    if (state_d.drv_rst) begin
      state_d.driver_ctrl = reset_source_pkg::DRIVER_RESET;
    end
    if (state_d.low_battery_rst) begin
      state_d.low_battery_ctrl = reset_source_pkg::DRIVER_RESET;
    end

    // Event flags
    if (supply_overvoltage) set_flags[reset_source_pkg::FLAG_SUPPLY_OV] = 1'b1;
    if (battery_ov_window) set_flags[reset_source_pkg::FLAG_BATTERY_OV] = 1'b1;
    if (link_activity_timeout) set_flags[reset_source_pkg::FLAG_LINK_FAIL] = 1'b1;
    // Reset toward the host drops flags the reset unit does not own
    if (state_q.pin_drive) begin
      state_d.flags[reset_source_pkg::FLAG_SUPPLY_OV] = 1'b0;
      state_d.flags[reset_source_pkg::FLAG_LINK_FAIL] = 1'b0;
    end
    if (rd_status) state_d.flags = '0;
    state_d.flags = state_d.flags | set_flags;
    state_d.irq   = |(state_d.flags & state_q.mask);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q                <= '0;
      state_q.driver_ctrl    <= reset_source_pkg::DRIVER_RESET;
      state_q.low_battery_ctrl <= reset_source_pkg::DRIVER_RESET;
      state_q.pin_state      <= reset_source_pkg::PIN_RELEASE_WAIT;
      state_q.pin_drive      <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flip-flops, reset_pin_out tied low
  assign prdata              = state_q.prdata;
  assign pready              = state_q.pready;
  assign pslverr             = state_q.pslverr;
  assign reset_pin_out       = 1'b0;
  assign reset_pin_oe_n      = !state_q.pin_drive;
  assign driver_domain_reset = state_q.drv_rst;
  assign low_battery_domain_reset = state_q.low_battery_rst;
  assign link_watchdog_reset = state_q.wd_rst;
  assign transceiver_reset   = state_q.xcv_rst;
  assign regulators_off      = state_q.reg_off;
  assign irq                 = state_q.irq;

endmodule : reset_source_manager
`default_nettype wire

// [test/host_side_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host side of the open-drain reset pin
// ----------------------------------------
module host_side_model (
  input  wire logic host_pull,
  input  wire logic reset_pin_out,
  input  wire logic reset_pin_oe_n,
  output var  logic reset_pin_in
);
  // Pulled-up wire, low when either side pulls; the bench holds host_pull both short of and past the filter
  always_comb reset_pin_in = ~((~reset_pin_oe_n & ~reset_pin_out) | host_pull);
endmodule : host_side_model
`default_nettype wire

// [test/reset_source_checks_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checks of the reset source manager
// ----------------------------------------
module reset_source_checks #(
  parameter int unsigned LATCH_EXIT_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic supply_overvoltage,
  input wire logic battery_ov_window,
  input wire logic link_activity_timeout,
  input wire logic power_latch_mode,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  input wire logic driver_domain_reset,
  input wire logic low_battery_domain_reset,
  input wire logic link_watchdog_reset,
  input wire logic transceiver_reset,
  input wire logic regulators_off
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [15:0] lo_q;
  logic [15:0] lo_d;
  // Cycles the pin has been driven low
  always_comb lo_d = reset_pin_oe_n ? 16'h0000 : lo_q + 16'h0001;
  always_ff @(posedge ref_clk) lo_q <= reset ? 16'h0000 : lo_d;
  sequence apb_req;
    psel && penable && !pready;
  endsequence
  sequence bov_ev;
    $rose(battery_ov_window) && reset_pin_oe_n;
  endsequence
  AST_APB_WAIT: assert property (apb_req |=> pready) else $error("late apb answer");
  AST_ERR_PAIR: assert property (pslverr |-> pready) else $error("error without ready");
  AST_OD_LOW: assert property (reset_pin_out == 1'b0) else $error("pin drives high");
  AST_BOV_DOM: assert property (bov_ev |-> ##[0:2] (driver_domain_reset && link_watchdog_reset
    && !transceiver_reset && !regulators_off)) else $error("battery window domains wrong");
  AST_BOV_PIN: assert property (bov_ev |=> reset_pin_oe_n[*3]) else $error("battery window drove pin");
  AST_LINK: assert property ($rose(link_activity_timeout) && reset_pin_oe_n |-> ##[0:2] (driver_domain_reset
    && !link_watchdog_reset && !low_battery_domain_reset && !transceiver_reset) ##1 reset_pin_oe_n)
    else $error("link expiry domains wrong");
  AST_SOV: assert property ($rose(supply_overvoltage) && reset_pin_oe_n |-> ##[0:2] driver_domain_reset
    ##1 reset_pin_oe_n) else $error("supply overvoltage drivers kept");
  AST_LATCH_LEN: assert property ($rose(reset_pin_oe_n) && power_latch_mode |->
    lo_q >= LATCH_EXIT_CYCLES && lo_q <= LATCH_EXIT_CYCLES + 2) else $error("latch exit length wrong");
  AST_FILTER: assert property ($fell(reset_pin_in) && reset_pin_oe_n |=> (!driver_domain_reset)[*8])
    else $error("pin low taken unfiltered");
endmodule : reset_source_checks
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bench top
// ----------------------------------------
module tb_top;
  logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr, irq, erv, drv_seen, host_pull;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        supply_ok, supply_overvoltage, battery_ov_window, battery_ov_long, link_activity_timeout;
  logic        power_latch_mode, ignition_in, reset_pin_in, reset_pin_out, reset_pin_oe_n, regulators_off;
  logic        driver_domain_reset, low_battery_domain_reset, link_watchdog_reset, transceiver_reset;
  int          bad_count, n_checks;
  localparam logic [31:0] DR = reset_source_pkg::DRIVER_RESET;
  reset_source_manager #(.LATCH_EXIT_CYCLES(20), .RELEASE_DELAY_CYCLES(50), .HOLD_TIME_CYCLES(300)) dut_u (
    .ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_ok,
    .supply_overvoltage, .battery_ov_window, .battery_ov_long, .link_activity_timeout, .power_latch_mode,
    .ignition_in, .reset_pin_in, .reset_pin_out, .reset_pin_oe_n, .driver_domain_reset, .low_battery_domain_reset,
    .link_watchdog_reset, .transceiver_reset, .regulators_off, .irq);
  host_side_model host_u (.host_pull, .reset_pin_out, .reset_pin_oe_n, .reset_pin_in);
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Notes any cycle with the pin driven
  always @(posedge ref_clk) if (reset_pin_oe_n === 1'b0) drv_seen <= 1'b1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic prep(input logic [31:0] m);
    apb(1'b1, reset_source_pkg::ADDR_MASK, m);
    apb(1'b1, reset_source_pkg::ADDR_CONFIG, 32'h0000_00A5);
    apb(1'b1, reset_source_pkg::ADDR_LOW_BAT_CFG, 32'h0000_005A);
    apb(1'b1, reset_source_pkg::ADDR_DRIVER, 32'h0000_0000);
    apb(1'b1, reset_source_pkg::ADDR_LOW_BAT_DRV, 32'h0000_0000);
    apb(1'b0, reset_source_pkg::ADDR_STATUS, 32'h0);
    drv_seen = 1'b0;
  endtask : prep
  task automatic post(input logic [31:0] f, input logic [31:0] c, input logic [31:0] l, input logic [31:0] d);
    apb(1'b0, reset_source_pkg::ADDR_STATUS, 32'h0);
    chk("status", f, rdv);
    apb(1'b0, reset_source_pkg::ADDR_CONFIG, 32'h0);
    chk("config", c, rdv);
    apb(1'b0, reset_source_pkg::ADDR_LOW_BAT_CFG, 32'h0);
    chk("low_bat_config", l, rdv);
    apb(1'b0, reset_source_pkg::ADDR_DRIVER, 32'h0);
    chk("driver", d, rdv);
  endtask : post
  task automatic t_bov;
    prep(32'h0000_000F);
    battery_ov_window <= 1'b1;
    tick(2);
    battery_ov_window <= 1'b0;
    tick(4);
    chk("bov_irq", 1, irq);
    post(32'h2, 32'hA5, 32'h5A, DR);
    chk("bov_clear_irq", 0, irq);
    chk("bov_pin", 0, drv_seen);
    apb(1'b0, reset_source_pkg::ADDR_LOW_BAT_DRV, 32'h0);
    chk("bov_lowbat_drv", DR, rdv);
  endtask : t_bov
  task automatic t_link;
    prep(32'h0);
    link_activity_timeout <= 1'b1;
    tick(1);
    link_activity_timeout <= 1'b0;
    tick(4);
    chk("masked_irq", 0, irq);
    post(32'h4, 32'hA5, 32'h5A, DR);
    chk("link_pin", 0, drv_seen);
    apb(1'b0, reset_source_pkg::ADDR_LOW_BAT_DRV, 32'h0);
    chk("link_lowbat_drv", 0, rdv);
  endtask : t_link
  task automatic t_sov;
    prep(32'h0000_000F);
    supply_overvoltage <= 1'b1;
    tick(1);
    supply_overvoltage <= 1'b0;
    tick(4);
    post(32'h1, 32'hA5, 32'h5A, DR);
    apb(1'b1, reset_source_pkg::ADDR_DRIVER, 32'h0000_0000);
    apb(1'b0, reset_source_pkg::ADDR_DRIVER, 32'h0);
    chk("sov_reenable", 0, rdv);
    apb(1'b0, reset_source_pkg::ADDR_LOW_BAT_DRV, 32'h0);
    chk("sov_lowbat_drv", 0, rdv);
  endtask : t_sov
  task automatic t_soft;
    prep(32'h0000_000F);
    apb(1'b1, reset_source_pkg::ADDR_COMMAND, 32'h0000_0001);
    tick(4);
    post(32'h0, 32'h0, 32'h0, DR);
    chk("soft_pin", 0, drv_seen);
    apb(1'b0, reset_source_pkg::ADDR_LOW_BAT_DRV, 32'h0);
    chk("soft_lowbat_drv", DR, rdv);
  endtask : t_soft
  task automatic t_pin(input int n, input logic [31:0] c, input logic [31:0] l, input logic [31:0] d);
    prep(32'h0);
    host_pull <= 1'b1;
    tick(n);
    host_pull <= 1'b0;
    tick(2);
    while (reset_pin_oe_n !== 1'b1) @(posedge ref_clk);
    tick(4);
    post(32'h0, c, l, d);
  endtask : t_pin
  task automatic t_blong;
    prep(32'h0);
    battery_ov_long <= 1'b1;
    tick(3);
    chk("blong_reg_off", 1, regulators_off);
    chk("blong_pin", 0, reset_pin_oe_n);
    battery_ov_long <= 1'b0;
    while (reset_pin_oe_n !== 1'b1) @(posedge ref_clk);
    tick(2);
    chk("blong_reg_on", 0, regulators_off);
    post(32'h2, 32'h0, 32'h0, DR);
  endtask : t_blong
  task automatic t_latch;
    int n;
    prep(32'h0);
    apb(1'b1, reset_source_pkg::ADDR_CONFIG, 32'h0000_0001);
    power_latch_mode <= 1'b1;
    tick(2);
    ignition_in <= 1'b1;
    repeat (10) if (reset_pin_oe_n !== 1'b0) tick(1);
    n = 0;
    while (reset_pin_oe_n === 1'b0) begin
      tick(1);
      n++;
    end
    chk("latch_len", 1, n >= 18 && n <= 22);
    power_latch_mode <= 1'b0;
    ignition_in      <= 1'b0;
    apb(1'b0, reset_source_pkg::ADDR_STATUS, 32'h0);
    chk("latch_flag", 32'h8, rdv);
  endtask : t_latch
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // Hang guard
  initial begin
    #500000;
    bad_count++;
    results();
  end
  // Main sequence
  initial begin
    int n;
    {psel, penable, pwrite, paddr, pwdata, host_pull} = '0;
    {supply_overvoltage, battery_ov_window, battery_ov_long, link_activity_timeout} = '0;
    {power_latch_mode, ignition_in, supply_ok, drv_seen} = '0;
    reset = 1'b1;
    tick(8);
    reset <= 1'b0;
    tick(4);
    supply_ok <= 1'b1;
    n = 0;
    while (reset_pin_oe_n !== 1'b1) begin
      tick(1);
      n++;
    end
    chk("release_delay", 1, n >= 50 && n <= 54);
    apb(1'b0, reset_source_pkg::ADDR_DRIVER, 32'h0);
    chk("driver_reset", DR, rdv);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", 1, erv);
    t_bov();
    t_link();
    t_sov();
    t_soft();
    t_pin(100, 32'hA5, 32'h5A, 32'h0);
    t_pin(250, 32'h0, 32'h5A, DR);
    t_pin(350, 32'h0, 32'h0, DR);
    t_blong();
    t_latch();
    results();
  end
endmodule : tb_top
bind reset_source_manager reset_source_checks #(.LATCH_EXIT_CYCLES(LATCH_EXIT_CYCLES)) chk_u (
  .ref_clk, .reset, .psel, .penable, .pready, .pslverr, .supply_overvoltage, .battery_ov_window,
  .link_activity_timeout, .power_latch_mode, .reset_pin_in, .reset_pin_out, .reset_pin_oe_n,
  .driver_domain_reset, .low_battery_domain_reset, .link_watchdog_reset, .transceiver_reset, .regulators_off);
`default_nettype wire
